/* hdl/simd_unit_state_control.sv */
`timescale 1ns/1ns
`default_nettype none
`include "simd_consts.svh"
module simd_unit_state_control (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire simd_pkg::req_t req,
    output simd_pkg::rsp_t rsp,
    output logic [0:63] machine_state_word_out,
    output logic [0:31] condition_flags_out,
    output logic [`STREAM_COUNT-1:0] prefetch_en
);
    typedef struct packed {
        logic [0:31] simd_reg_usage_mask;
        logic [0:31] condition_flags;
        logic [0:63] machine_state_word;
        logic [0:63] saved_return_address;
        logic [0:63] saved_machine_state;
        logic [`STREAM_COUNT-1:0] stream_active;
        logic [`STREAM_COUNT-1:0] stream_user;
        logic [`STREAM_COUNT-1:0] stream_held;
        logic [`STREAM_COUNT-1:0] prefetch_en;
        simd_pkg::rsp_t rsp;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic avail;
    logic user_mode;
    logic xlate_on;
    logic take_unavail;
    logic take_priv;
    logic supervisor_sel;

    assign avail = cur.machine_state_word[`MSW_AVAIL_BIT];
    assign user_mode = cur.machine_state_word[`MSW_USER_BIT];
    assign xlate_on = cur.machine_state_word[`MSW_XLATE_BIT];
    assign supervisor_sel = (req.sel == simd_pkg::SEL_MACHINE_STATE) ||
                            (req.sel == simd_pkg::SEL_SAVED_ADDR) ||
                            (req.sel == simd_pkg::SEL_SAVED_STATE);

    always_comb begin
        take_priv = 1'b0;
        take_unavail = 1'b0;
        if (req.valid) begin
            // user mode may not touch supervisor registers or return
            if (user_mode && (req.op == simd_pkg::OP_MOVE_FROM ||
                req.op == simd_pkg::OP_MOVE_TO) && supervisor_sel) begin
                take_priv = 1'b1;
            end else if (user_mode && req.op == simd_pkg::OP_RETURN) begin
                take_priv = 1'b1;
            end
            // only register-file and status accesses are gated
            if (!take_priv && !req.higher_pri_pending && !avail &&
                (req.op == simd_pkg::OP_VEC_ACCESS ||
                 req.op == simd_pkg::OP_VCMP ||
                 req.op == simd_pkg::OP_VCMP_BOUNDS)) begin
                take_unavail = 1'b1;
            end
        end
    end

    always_comb begin
        next_cur = cur;
        next_cur.rsp.done = 1'b0;
        next_cur.rsp.proceed = 1'b0;
        next_cur.rsp.unavail_exc = 1'b0;
        next_cur.rsp.priv_exc = 1'b0;
        next_cur.rsp.redirect = 1'b0;
        if (req.valid) begin
            next_cur.rsp.done = 1'b1;
        end
        if (take_unavail || take_priv) begin
            next_cur.rsp.unavail_exc = take_unavail;
            next_cur.rsp.priv_exc = take_priv;
            next_cur.saved_return_address = req.ea;
            next_cur.saved_machine_state =
                (cur.saved_machine_state & ~`SAVE_COPY_MASK &
                 ~`SAVE_CLEAR_MASK) |
                (cur.machine_state_word & `SAVE_COPY_MASK);
            next_cur.stream_held = '1;
        end else if (req.valid) begin
            case (req.op)
                simd_pkg::OP_VEC_ACCESS: begin
                    next_cur.rsp.proceed = 1'b1;
                end
                simd_pkg::OP_VCMP: begin
                    next_cur.rsp.proceed = 1'b1;
                    if (req.record_flag) begin
                        // field six only, other fields keep their value
                        next_cur.condition_flags[`CMP_FIELD_LO:`CMP_FIELD_HI]
                            = 4'h0;
                        next_cur.condition_flags[`CMP_ALL_TRUE_BIT] =
                            req.all_true;
                        next_cur.condition_flags[`CMP_ALL_FALSE_BIT] =
                            req.all_false;
                    end
                    // no record flag: flags untouched
                end
                simd_pkg::OP_VCMP_BOUNDS: begin
                    next_cur.rsp.proceed = 1'b1;
                    if (req.record_flag) begin
                        next_cur.condition_flags[`CMP_FIELD_LO:`CMP_FIELD_HI]
                            = 4'h0;
                        next_cur.condition_flags[`CMP_ALL_FALSE_BIT] =
                            req.all_in_bounds;
                    end
                end
                simd_pkg::OP_MOVE_FROM: begin
                    next_cur.rsp.proceed = 1'b1;
                    next_cur.rsp.rdata = 64'h0000_0000_0000_0000;
                    if (req.sel == simd_pkg::SEL_USAGE_MASK) begin
                        next_cur.rsp.rdata[32:63] =
                            cur.simd_reg_usage_mask;
                    end else if (req.sel == simd_pkg::SEL_COND_FLAGS) begin
                        next_cur.rsp.rdata[32:63] = cur.condition_flags;
                    end else if (req.sel == simd_pkg::SEL_MACHINE_STATE) begin
                        next_cur.rsp.rdata = cur.machine_state_word;
                    end else if (req.sel == simd_pkg::SEL_SAVED_ADDR) begin
                        next_cur.rsp.rdata = cur.saved_return_address;
                    end else if (req.sel == simd_pkg::SEL_SAVED_STATE) begin
                        next_cur.rsp.rdata = cur.saved_machine_state;
                    end
                end
                simd_pkg::OP_MOVE_TO: begin
                    next_cur.rsp.proceed = 1'b1;
                    if (req.sel == simd_pkg::SEL_USAGE_MASK) begin
                        next_cur.simd_reg_usage_mask =
                            req.wdata[32:63];
                    end else if (req.sel == simd_pkg::SEL_COND_FLAGS) begin
                        next_cur.condition_flags = req.wdata[32:63];
                    end else if (req.sel == simd_pkg::SEL_MACHINE_STATE) begin
                        next_cur.machine_state_word = req.wdata;
                    end else if (req.sel == simd_pkg::SEL_SAVED_ADDR) begin
                        next_cur.saved_return_address = req.wdata;
                    end else if (req.sel == simd_pkg::SEL_SAVED_STATE) begin
                        next_cur.saved_machine_state = req.wdata;
                    end
                end
                simd_pkg::OP_STREAM_TOUCH: begin
                    next_cur.rsp.proceed = 1'b1;
                    // real-mode touch is dropped: safest of the undefined
                    if (xlate_on) begin
                        next_cur.stream_active[req.stream_id] = 1'b1;
                        next_cur.stream_user[req.stream_id] = user_mode;
                        next_cur.stream_held[req.stream_id] = 1'b0;
                    end
                end
                simd_pkg::OP_STREAM_STOP: begin
                    next_cur.rsp.proceed = 1'b1;
                    if (req.stop_all) begin
                        next_cur.stream_active = '0;
                    end else begin
                        next_cur.stream_active[req.stream_id] = 1'b0;
                    end
                end
                simd_pkg::OP_RETURN: begin
                    next_cur.rsp.proceed = 1'b1;
                    next_cur.machine_state_word =
                        cur.saved_machine_state;
                    next_cur.rsp.redirect = 1'b1;
                    next_cur.rsp.redirect_addr =
                        cur.saved_return_address;
                end
                default: begin
                    next_cur.rsp.done = 1'b0;
                end
            endcase
        end
        // evaluated on the state that the next cycle will see
        for (int i = 0; i < `STREAM_COUNT; i++) begin
            next_cur.prefetch_en[i] = next_cur.stream_active[i] &
                ~next_cur.stream_held[i] &
                next_cur.machine_state_word[`MSW_XLATE_BIT] &
                (next_cur.machine_state_word[`MSW_USER_BIT] ==
                 next_cur.stream_user[i]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur.simd_reg_usage_mask <= `USAGE_MASK_RESET;
            cur.condition_flags <= `COND_FLAGS_RESET;
            cur.machine_state_word <= `MSW_RESET;
            cur.saved_return_address <= `SAVED_RESET;
            cur.saved_machine_state <= `SAVED_RESET;
            cur.stream_active <= '0;
            cur.stream_user <= '0;
            cur.stream_held <= '0;
            cur.prefetch_en <= '0;
            cur.rsp <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rsp = cur.rsp;
    assign machine_state_word_out = cur.machine_state_word;
    assign condition_flags_out = cur.condition_flags;
    assign prefetch_en = cur.prefetch_en;
endmodule
`default_nettype wire

/* hdl/simd_consts.svh */
// Operation
// - usage mask bit n marks vector register n used; hardware never alters.
// - usage mask is reached only by move-from and move-to special register.
// - condition flags: 32 bits, eight 4-bit fields numbered zero to seven.
// - vector compare writes field six only when its record flag is set.
// - plain compare sets bit 24 when relation holds for all; 25, 27 zero.
// - ordinary compare sets bit 26 when relation is false for all pairs.
// - bounds compare: bit 24 zero, bit 26 set when all elements in bounds.
// - user access to supervisor registers raises a privilege exception.
// - machine state word is 64 bits with the unit-available bit at 38.
// - bit 38 zero traps register file and status accesses; one allows.
// - usage mask accesses are never trapped by the available bit.
// - stream touch and stop ignore the available bit and never trap.
// - stream touch is supported only with data translation bit 59 set.
// - stream prefetch needs translation on and bit 49 as when started.
// - any exception taken suspends prefetching for every data stream.
// - bit 49 zero runs all instructions; one runs user-level ones only.
// - unavailable trap only when no higher-priority exception is pending.
// - unavailable trap saves the faulting effective address.
// - saved state: clear 33-36, 42-47; copy 0, 48-55, 57-59, 62-63.
// - return from interrupt restores state from both save registers.
`ifndef SIMD_CONSTS_SVH
`define SIMD_CONSTS_SVH
// big-endian bit positions, bit 0 is the most significant
`define MSW_AVAIL_BIT 38
`define MSW_USER_BIT 49
`define MSW_XLATE_BIT 59
`define CMP_FIELD_LO 24
`define CMP_FIELD_HI 27
`define CMP_ALL_TRUE_BIT 24
`define CMP_ALL_FALSE_BIT 26
// saved state: ones mark bits copied from the machine state word
`define SAVE_COPY_MASK 64'h8000_0000_0000_FF73
// saved state: ones mark bits forced to zero (33-36, 42-47)
`define SAVE_CLEAR_MASK 64'h0000_0000_783F_0000
`define USAGE_MASK_RESET 32'h0000_0000
`define COND_FLAGS_RESET 32'h0000_0000
`define MSW_RESET 64'h0000_0000_0000_0000
`define SAVED_RESET 64'h0000_0000_0000_0000
`define STREAM_COUNT 4
`endif

/* hdl/simd_pkg.sv */
package simd_pkg;
    typedef enum logic [8:0] {
        OP_NONE = 9'h001,
        OP_VEC_ACCESS = 9'h002,
        OP_VCMP = 9'h004,
        OP_VCMP_BOUNDS = 9'h008,
        OP_MOVE_FROM = 9'h010,
        OP_MOVE_TO = 9'h020,
        OP_STREAM_TOUCH = 9'h040,
        OP_STREAM_STOP = 9'h080,
        OP_RETURN = 9'h100
    } op_kind_t;
    typedef enum logic [4:0] {
        SEL_USAGE_MASK = 5'h01,
        SEL_COND_FLAGS = 5'h02,
        SEL_MACHINE_STATE = 5'h04,
        SEL_SAVED_ADDR = 5'h08,
        SEL_SAVED_STATE = 5'h10
    } reg_sel_t;
    typedef struct packed {
        logic valid;
        op_kind_t op;
        reg_sel_t sel;
        logic [0:63] wdata;
        logic [0:63] ea;
        logic record_flag;
        logic all_true;
        logic all_false;
        logic all_in_bounds;
        logic higher_pri_pending;
        logic [1:0] stream_id;
        logic stop_all;
    } req_t;
    typedef struct packed {
        logic done;
        logic [0:63] rdata;
        logic proceed;
        logic unavail_exc;
        logic priv_exc;
        logic redirect;
        logic [0:63] redirect_addr;
    } rsp_t;
endpackage

/* tb/simd_state_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "simd_consts.svh"
module simd_state_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire simd_pkg::req_t req,
    input wire simd_pkg::rsp_t rsp,
    input wire logic [0:63] machine_state_word_out,
    input wire logic [0:31] condition_flags_out,
    input wire logic [`STREAM_COUNT-1:0] prefetch_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence vec_req_s;
        req.valid && req.op inside {simd_pkg::OP_VEC_ACCESS,
            simd_pkg::OP_VCMP, simd_pkg::OP_VCMP_BOUNDS};
    endsequence
    sequence rec_cmp_s;
        req.valid && req.record_flag && machine_state_word_out[38];
    endsequence
    sequence user_req_s;
        req.valid && machine_state_word_out[49];
    endsequence
    unavail_trap_a: assert property (vec_req_s ##0
        (!machine_state_word_out[38] && !req.higher_pri_pending)
        |=> rsp.unavail_exc && rsp.done) else $error("no unavailable trap");
    avail_run_a: assert property (vec_req_s ##0
        machine_state_word_out[38] |=> rsp.proceed && !rsp.unavail_exc)
        else $error("available op trapped");
    pri_block_a: assert property (vec_req_s ##0
        req.higher_pri_pending |=> !rsp.unavail_exc)
        else $error("trap despite higher priority");
    mask_free_a: assert property (req.valid &&
        req.sel == simd_pkg::SEL_USAGE_MASK && req.op inside
        {simd_pkg::OP_MOVE_FROM, simd_pkg::OP_MOVE_TO} |=> rsp.proceed)
        else $error("usage mask access blocked");
    stream_free_a: assert property (req.valid && req.op inside
        {simd_pkg::OP_STREAM_TOUCH, simd_pkg::OP_STREAM_STOP}
        |=> rsp.proceed && !rsp.unavail_exc) else $error("stream op trapped");
    user_trap_a: assert property (user_req_s ##0
        req.op == simd_pkg::OP_RETURN |=> rsp.priv_exc && !rsp.redirect)
        else $error("user return not refused");
    super_trap_a: assert property (user_req_s ##0
        req.op inside {simd_pkg::OP_MOVE_FROM, simd_pkg::OP_MOVE_TO} &&
        req.sel inside {simd_pkg::SEL_MACHINE_STATE,
        simd_pkg::SEL_SAVED_ADDR, simd_pkg::SEL_SAVED_STATE}
        |=> rsp.priv_exc && !rsp.proceed)
        else $error("user supervisor access not refused");
    cmp_write_a: assert property (rec_cmp_s ##0
        req.op == simd_pkg::OP_VCMP |=> condition_flags_out[24:27] ==
        {$past(req.all_true), 1'b0, $past(req.all_false), 1'b0})
        else $error("compare field wrong");
    bounds_write_a: assert property (rec_cmp_s ##0
        req.op == simd_pkg::OP_VCMP_BOUNDS |=> condition_flags_out[24:27]
        == {2'b00, $past(req.all_in_bounds), 1'b0})
        else $error("bounds field wrong");
    norec_keep_a: assert property (req.valid && !req.record_flag &&
        req.op inside {simd_pkg::OP_VCMP, simd_pkg::OP_VCMP_BOUNDS}
        |=> $stable(condition_flags_out)) else $error("flags changed");
    exc_stop_a: assert property (rsp.unavail_exc || rsp.priv_exc
        |-> prefetch_en == '0) else $error("prefetch on after exception");
endmodule
bind simd_unit_state_control simd_state_checker u_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .req(req),
    .rsp(rsp),
    .machine_state_word_out(machine_state_word_out),
    .condition_flags_out(condition_flags_out),
    .prefetch_en(prefetch_en)
);
`default_nettype wire

/* tb/simd_unit_state_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "simd_consts.svh"
module simd_unit_state_control_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    simd_pkg::req_t req;
    simd_pkg::req_t nx;
    simd_pkg::rsp_t rsp;
    logic [0:63] msw_out, msw, sav, adr, r;
    logic [0:31] flags_out, flg;
    logic [`STREAM_COUNT-1:0] pf;
    logic bnd;
    int miscompares = 0;
    int samples_checked = 0;
    simd_unit_state_control u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .req(req), .rsp(rsp), .machine_state_word_out(msw_out),
        .condition_flags_out(flags_out), .prefetch_en(pf));
    always #4 core_clk = ~core_clk;
    task automatic chk(input logic [0:63] got, input logic [0:63] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: value %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: flag %b not %b", $time, got, exp);
        end
    endtask
    // extra request fields come from nx, cleared after every request
    task automatic run(input simd_pkg::op_kind_t op,
        input simd_pkg::reg_sel_t sel, input logic [0:63] d);
        simd_pkg::req_t q;
        q = nx;
        q.valid = 1'b1;
        q.op = op;
        q.sel = sel;
        q.wdata = d;
        q.ea = d;
        @(posedge core_clk);
        req <= q;
        @(posedge core_clk);
        req.valid <= 1'b0;
        nx = '0;
        #1;
    endtask
    task automatic wr(input simd_pkg::reg_sel_t sel, input logic [0:63] d);
        run(simd_pkg::OP_MOVE_TO, sel, d);
    endtask
    task automatic rd(input simd_pkg::reg_sel_t sel, input logic [0:63] e);
        run(simd_pkg::OP_MOVE_FROM, sel, '0);
        chk(rsp.rdata, e);
    endtask
    function automatic logic [0:63] save_exp(logic [0:63] old, logic [0:63] m);
        save_exp = old;
        for (int i = 0; i < 64; i++) begin
            if (i inside {[33:36], [42:47]}) save_exp[i] = 1'b0;
            else if (i inside {0, [48:55], [57:59], [62:63]})
                save_exp[i] = m[i];
        end
    endfunction
    task automatic stop_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        stop_test();
    end
    initial begin
        req = '0;
        req.op = simd_pkg::OP_NONE;
        nx = '0;
        void'($urandom(80));
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(simd_pkg::reg_sel_t'(5'h01 << i), '0);
        r = {$urandom, $urandom};
        wr(simd_pkg::SEL_USAGE_MASK, r);
        rd(simd_pkg::SEL_USAGE_MASK, {32'h0, r[32:63]});
        msw = {$urandom, $urandom};
        msw[38] = 1'b0;
        msw[49] = 1'b0;
        msw[59] = 1'b1;
        wr(simd_pkg::SEL_MACHINE_STATE, msw);
        chk(msw_out, msw);
        nx.stream_id = 2'h2;
        run(simd_pkg::OP_STREAM_TOUCH, simd_pkg::SEL_USAGE_MASK, '0);
        chk_bit(rsp.proceed, 1'b1);
        chk_bit(pf[2], 1'b1);
        sav = {$urandom, $urandom};
        wr(simd_pkg::SEL_SAVED_STATE, sav);
        adr = {$urandom, $urandom};
        run(simd_pkg::OP_VEC_ACCESS, simd_pkg::SEL_USAGE_MASK, adr);
        chk_bit(rsp.unavail_exc, 1'b1);
        chk(64'(pf), '0);
        sav = save_exp(sav, msw);
        rd(simd_pkg::SEL_SAVED_ADDR, adr);
        rd(simd_pkg::SEL_SAVED_STATE, sav);
        nx.higher_pri_pending = 1'b1;
        run(simd_pkg::OP_VCMP, simd_pkg::SEL_USAGE_MASK, '0);
        chk_bit(rsp.unavail_exc, 1'b0);
        msw[38] = 1'b1;
        wr(simd_pkg::SEL_MACHINE_STATE, msw);
        flg = $urandom;
        wr(simd_pkg::SEL_COND_FLAGS, {32'h0, flg});
        repeat (40) begin
            nx.record_flag = 1'($urandom_range(1));
            nx.all_true = 1'($urandom_range(1));
            nx.all_false = ~nx.all_true & 1'($urandom_range(1));
            nx.all_in_bounds = 1'($urandom_range(1));
            bnd = 1'($urandom_range(1));
            if (nx.record_flag) flg[24:27] = bnd ?
                {2'b00, nx.all_in_bounds, 1'b0} :
                {nx.all_true, 1'b0, nx.all_false, 1'b0};
            run(bnd ? simd_pkg::OP_VCMP_BOUNDS : simd_pkg::OP_VCMP,
                simd_pkg::SEL_USAGE_MASK, '0);
            chk({32'h0, flags_out}, {32'h0, flg});
        end
        rd(simd_pkg::SEL_USAGE_MASK, {32'h0, r[32:63]});
        run(simd_pkg::OP_RETURN, simd_pkg::SEL_USAGE_MASK, '0);
        chk(rsp.redirect_addr, adr);
        chk(msw_out, sav);
        msw = sav;
        msw[49] = 1'b0;
        msw[59] = 1'b0;
        wr(simd_pkg::SEL_MACHINE_STATE, msw);
        nx.stream_id = 2'h1;
        run(simd_pkg::OP_STREAM_TOUCH, simd_pkg::SEL_USAGE_MASK, '0);
        chk_bit(pf[1], 1'b0);
        msw[59] = 1'b1;
        wr(simd_pkg::SEL_MACHINE_STATE, msw);
        nx.stream_id = 2'h1;
        run(simd_pkg::OP_STREAM_TOUCH, simd_pkg::SEL_USAGE_MASK, '0);
        chk_bit(pf[1], 1'b1);
        msw[49] = 1'b1;
        wr(simd_pkg::SEL_MACHINE_STATE, msw);
        chk_bit(pf[1], 1'b0);
        run(simd_pkg::OP_MOVE_FROM, simd_pkg::SEL_MACHINE_STATE, '0);
        chk_bit(rsp.priv_exc, 1'b1);
        run(simd_pkg::OP_RETURN, simd_pkg::SEL_USAGE_MASK, '0);
        chk_bit(rsp.priv_exc, 1'b1);
        rd(simd_pkg::SEL_USAGE_MASK, {32'h0, r[32:63]});
        stop_test();
    end
endmodule
`default_nettype wire
